// file: inc/psm_consts.vh
// constants for the pack safety fault monitor
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH

// register byte addresses
`define PSM_ADDR_CONFIG      8'h00
`define PSM_ADDR_OTC_THRESH  8'h04
`define PSM_ADDR_OTC_RECOV   8'h08
`define PSM_ADDR_OTD_THRESH  8'h0c
`define PSM_ADDR_OTD_RECOV   8'h10
`define PSM_ADDR_CHG_CUR_TH  8'h14
`define PSM_ADDR_DSG_CUR_TH  8'h18
`define PSM_ADDR_OTC_TIME    8'h1c
`define PSM_ADDR_OTD_TIME    8'h20
`define PSM_ADDR_WDOG_TIME   8'h24
`define PSM_ADDR_SOV_THRESH  8'h28
`define PSM_ADDR_SOV_TIME    8'h2c
`define PSM_ADDR_SAFE_ALERT  8'h30
`define PSM_ADDR_SAFE_STAT   8'h34
`define PSM_ADDR_PERMANENT_FAIL_ALERT_WORD    8'h38
`define PSM_ADDR_PF_STAT     8'h3c
`define PSM_ADDR_BATT_STAT   8'h40
`define PSM_ADDR_OP_STAT     8'h44
`define PSM_ADDR_FUSE_FLAG   8'h48
`define PSM_ADDR_SNAP_VOLT   8'h4c
`define PSM_ADDR_SNAP_CUR    8'h50
`define PSM_ADDR_SNAP_TEMP   8'h54

// config register fields
`define PSM_CFG_OVERTEMP_SWITCH_OPEN_ENABLE_BIT    0
`define PSM_CFG_FUSE_EN_BIT  1
`define PSM_CFG_WDOG_FET_BIT 2
`define PSM_CFG_RESET        16'h0000

// status field positions
`define PSM_SA_OTC_BIT       0
`define PSM_SA_OTD_BIT       1
`define PSM_SS_HOST_INACTIVITY_FAULT_BIT      2
`define PSM_PF_SOV_BIT       0
`define PSM_BS_TCA_BIT       0
`define PSM_BS_TDA_BIT       1
`define PSM_BS_OTA_BIT       2
`define PSM_OS_DISCHARGE_DISABLED_FLAG_BIT      0

// reset values, temperature in 1 degC per lsb, two's complement
`define PSM_OTC_THRESH_RST   16'h0037
`define PSM_OTC_RECOV_RST    16'h0032
`define PSM_OTD_THRESH_RST   16'h003c
`define PSM_OTD_RECOV_RST    16'h0037
`define PSM_CUR_TH_RST       16'h0064
`define PSM_OT_TIME_RST      16'h0002
`define PSM_WDOG_TIME_RST    16'h0000
`define PSM_SOV_THRESH_RST   16'hffff
`define PSM_SOV_TIME_RST     16'h0000
`define PSM_FUSE_MAGIC       16'h3672

// seconds tick
`define PSM_TICK_TIME_MS     1000
`define PSM_CLK_KHZ          100000

`endif

// file: core/psm_dbnc_timer.v
// debounce timer: alert flag, seconds count, one-cycle expiry pulse
`timescale 1ns/1ns
module psm_dbnc_timer #(
    parameter TW = 16
) (
    // clock and reset
    input  wire          mclk,
    input  wire          sys_rst,
    // control
    input  wire          tick,
    input  wire          cond,
    input  wire [TW-1:0] limit,
    // results
    output reg           alert_q,
    output reg           expire_q
);
    reg [TW-1:0] cnt_q;
    wire         live = cond && (limit != {TW{1'b0}});

    always @(posedge mclk) begin
        if (sys_rst) begin
            alert_q  <= 1'b0;
            expire_q <= 1'b0;
            cnt_q    <= {TW{1'b0}};
        end else begin
            alert_q  <= live;
            expire_q <= 1'b0;
            if (!live || !alert_q) begin
                // restarts each time the alert first rises
                cnt_q <= {TW{1'b0}};
            end else if (tick) begin
                if (cnt_q + 1'b1 >= limit) begin
                    expire_q <= 1'b1;
                    cnt_q    <= {TW{1'b0}};
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
endmodule

// file: core/psm_monitor.v
// pack safety fault monitor: over-temperature, host watchdog, safety over-voltage
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
`include "psm_consts.vh"
module psm_monitor #(
    parameter DW          = 16,
    parameter TICK_CYCLES = `PSM_TICK_TIME_MS * `PSM_CLK_KHZ
) (
    // clock and reset
    input  wire          mclk,
    input  wire          sys_rst,
    // register port
    input  wire [7:0]    reg_addr,
    input  wire [DW-1:0] reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [DW-1:0] reg_rdata_q,
    // measurements, temperature and current signed two's complement, voltage unsigned
    input  wire [DW-1:0] pack_temp,
    input  wire [DW-1:0] pack_current,
    input  wire [DW-1:0] pack_voltage,
    // power state
    input  wire          normal_mode,
    input  wire          bus_low_expired,
    // charge requests from the charging algorithm
    input  wire [DW-1:0] chg_current_in,
    input  wire [DW-1:0] chg_voltage_in,
    output reg  [DW-1:0] chg_current_req_q,
    output reg  [DW-1:0] chg_voltage_req_q,
    // switches and protection outputs
    output reg           chg_switch_open_q,
    output reg           dsg_switch_open_q,
    output reg           prechg_switch_open_q,
    output reg           fuse_blow_q,
    output reg           nv_write_block_q
);
    // one-second tick
    reg  [31:0]   tick_cnt_q;
    reg           tick_q;

    // configuration
    reg  [DW-1:0] config_q;
    reg  [DW-1:0] otc_thresh_q;
    reg  [DW-1:0] otc_recov_q;
    reg  [DW-1:0] otd_thresh_q;
    reg  [DW-1:0] otd_recov_q;
    reg  [DW-1:0] chg_cur_th_q;
    reg  [DW-1:0] dsg_cur_th_q;
    reg  [DW-1:0] otc_time_q;
    reg  [DW-1:0] otd_time_q;
    reg  [DW-1:0] wdog_time_q;
    reg  [DW-1:0] sov_thresh_q;
    reg  [DW-1:0] sov_time_q;

    // fault state
    reg           charge_overtemp_flag_q;
    reg           discharge_overtemp_flag_q;
    reg           host_inactivity_fault_q;
    reg           pack_overvoltage_permanent_flag_q;
    reg  [DW-1:0] fuse_flag_q;
    reg  [DW-1:0] snap_volt_q;
    reg  [DW-1:0] snap_cur_q;
    reg  [DW-1:0] snap_temp_q;
    reg  [DW-1:0] wdog_cnt_q;

    wire          otc_alert;
    wire          otc_expire;
    wire          otd_alert;
    wire          otd_expire;
    wire          sov_alert;
    wire          sov_expire;

    wire overtemp_switch_open_enable = config_q[`PSM_CFG_OVERTEMP_SWITCH_OPEN_ENABLE_BIT];
    wire overvoltage_fuse_enable     = config_q[`PSM_CFG_FUSE_EN_BIT];
    wire wdog_switch_enable          = config_q[`PSM_CFG_WDOG_FET_BIT];

    wire bus_access = reg_wr || reg_rd;

    // signed comparisons against programmed thresholds, unsigned for the voltage threshold
    wire signed [DW-1:0] temp_s    = pack_temp;
    wire signed [DW-1:0] cur_s     = pack_current;
    wire signed [DW-1:0] dsg_neg_s = -dsg_cur_th_q;
    wire otc_cond = ($signed(temp_s) >= $signed(otc_thresh_q)) &&
                    ($signed(cur_s) > $signed(chg_cur_th_q));
    wire otd_cond = ($signed(temp_s) >= $signed(otd_thresh_q)) &&
                    ($signed(cur_s) < dsg_neg_s);
    wire sov_cond = (pack_voltage >= sov_thresh_q);
    wire otc_recovered = $signed(temp_s) <= $signed(otc_recov_q);
    wire otd_recovered = $signed(temp_s) <= $signed(otd_recov_q);

    wire wdog_active = normal_mode && !bus_low_expired &&
                       (wdog_time_q != {DW{1'b0}});
    wire wdog_fire   = wdog_active && tick_q && !bus_access &&
                       (wdog_cnt_q + 1'b1 >= wdog_time_q);

    // seconds tick from the system clock
    always @(posedge mclk) begin
        if (sys_rst) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q     <= 1'b0;
        end
    end

    // debounce timers
    psm_dbnc_timer #(.TW(DW)) u_otc_timer (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .tick     (tick_q),
        .cond     (otc_cond && !charge_overtemp_flag_q),
        .limit    (otc_time_q),
        .alert_q  (otc_alert),
        .expire_q (otc_expire)
    );

    psm_dbnc_timer #(.TW(DW)) u_otd_timer (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .tick     (tick_q),
        .cond     (otd_cond && !discharge_overtemp_flag_q),
        .limit    (otd_time_q),
        .alert_q  (otd_alert),
        .expire_q (otd_expire)
    );

    psm_dbnc_timer #(.TW(DW)) u_sov_timer (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .tick     (tick_q),
        .cond     (sov_cond && !pack_overvoltage_permanent_flag_q),
        .limit    (sov_time_q),
        .alert_q  (sov_alert),
        .expire_q (sov_expire)
    );

    // register writes
    always @(posedge mclk) begin
        if (sys_rst) begin
            config_q     <= `PSM_CFG_RESET;
            otc_thresh_q <= `PSM_OTC_THRESH_RST;
            otc_recov_q  <= `PSM_OTC_RECOV_RST;
            otd_thresh_q <= `PSM_OTD_THRESH_RST;
            otd_recov_q  <= `PSM_OTD_RECOV_RST;
            chg_cur_th_q <= `PSM_CUR_TH_RST;
            dsg_cur_th_q <= `PSM_CUR_TH_RST;
            otc_time_q   <= `PSM_OT_TIME_RST;
            otd_time_q   <= `PSM_OT_TIME_RST;
            wdog_time_q  <= `PSM_WDOG_TIME_RST;
            sov_thresh_q <= `PSM_SOV_THRESH_RST;
            sov_time_q   <= `PSM_SOV_TIME_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `PSM_ADDR_CONFIG: begin
                    config_q <= reg_wdata;
                end
                `PSM_ADDR_OTC_THRESH: begin
                    otc_thresh_q <= reg_wdata;
                end
                `PSM_ADDR_OTC_RECOV: begin
                    otc_recov_q <= reg_wdata;
                end
                `PSM_ADDR_OTD_THRESH: begin
                    otd_thresh_q <= reg_wdata;
                end
                `PSM_ADDR_OTD_RECOV: begin
                    otd_recov_q <= reg_wdata;
                end
                `PSM_ADDR_CHG_CUR_TH: begin
                    chg_cur_th_q <= reg_wdata;
                end
                `PSM_ADDR_DSG_CUR_TH: begin
                    dsg_cur_th_q <= reg_wdata;
                end
                `PSM_ADDR_OTC_TIME: begin
                    otc_time_q <= reg_wdata;
                end
                `PSM_ADDR_OTD_TIME: begin
                    otd_time_q <= reg_wdata;
                end
                `PSM_ADDR_WDOG_TIME: begin
                    wdog_time_q <= reg_wdata;
                end
                `PSM_ADDR_SOV_THRESH: begin
                    sov_thresh_q <= reg_wdata;
                end
                `PSM_ADDR_SOV_TIME: begin
                    sov_time_q <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // over-temperature latches
    always @(posedge mclk) begin
        if (sys_rst) begin
            charge_overtemp_flag_q    <= 1'b0;
            discharge_overtemp_flag_q <= 1'b0;
        end else begin
            if (otc_time_q == {DW{1'b0}}) begin
                charge_overtemp_flag_q <= 1'b0;
            end else if (otc_expire) begin
                charge_overtemp_flag_q <= 1'b1;
            end else if (otc_recovered) begin
                charge_overtemp_flag_q <= 1'b0;
            end
            if (otd_time_q == {DW{1'b0}}) begin
                discharge_overtemp_flag_q <= 1'b0;
            end else if (otd_expire) begin
                discharge_overtemp_flag_q <= 1'b1;
            end else if (otd_recovered) begin
                discharge_overtemp_flag_q <= 1'b0;
            end
        end
    end

    // host inactivity watchdog
    always @(posedge mclk) begin
        if (sys_rst) begin
            wdog_cnt_q              <= {DW{1'b0}};
            host_inactivity_fault_q <= 1'b0;
        end else begin
            if (!wdog_active || bus_access || wdog_fire) begin
                wdog_cnt_q <= {DW{1'b0}};
            end else if (tick_q) begin
                wdog_cnt_q <= wdog_cnt_q + 1'b1;
            end
            if (wdog_fire) begin
                host_inactivity_fault_q <= 1'b1;
            end else if (bus_access) begin
                host_inactivity_fault_q <= 1'b0;
            end
        end
    end

    // permanent over-voltage failure, snapshots and fuse word
    always @(posedge mclk) begin
        if (sys_rst) begin
            pack_overvoltage_permanent_flag_q <= 1'b0;
            fuse_flag_q <= {DW{1'b0}};
            snap_volt_q <= {DW{1'b0}};
            snap_cur_q  <= {DW{1'b0}};
            snap_temp_q <= {DW{1'b0}};
        end else if (sov_expire) begin
            pack_overvoltage_permanent_flag_q <= 1'b1;
            snap_volt_q <= pack_voltage;
            snap_cur_q  <= pack_current;
            snap_temp_q <= pack_temp;
            if (overvoltage_fuse_enable) begin
                fuse_flag_q <= `PSM_FUSE_MAGIC;
            end
        end
    end

    // status words seen by software
    reg [DW-1:0] safe_alert;
    reg [DW-1:0] safe_stat;
    reg [DW-1:0] permanent_fail_alert_word;
    reg [DW-1:0] pf_stat;
    reg [DW-1:0] batt_stat;
    reg [DW-1:0] op_stat;
    reg          terminate_charge_alarm;
    reg          terminate_discharge_alarm;

    always @* begin
        terminate_charge_alarm = charge_overtemp_flag_q || host_inactivity_fault_q ||
              pack_overvoltage_permanent_flag_q;
        terminate_discharge_alarm = discharge_overtemp_flag_q || host_inactivity_fault_q ||
              pack_overvoltage_permanent_flag_q;
        safe_alert = {DW{1'b0}};
        safe_alert[`PSM_SA_OTC_BIT] = otc_alert;
        safe_alert[`PSM_SA_OTD_BIT] = otd_alert;
        safe_stat = {DW{1'b0}};
        safe_stat[`PSM_SA_OTC_BIT]  = charge_overtemp_flag_q;
        safe_stat[`PSM_SA_OTD_BIT]  = discharge_overtemp_flag_q;
        safe_stat[`PSM_SS_HOST_INACTIVITY_FAULT_BIT] = host_inactivity_fault_q;
        permanent_fail_alert_word = {DW{1'b0}};
        permanent_fail_alert_word[`PSM_PF_SOV_BIT] = sov_alert;
        pf_stat = {DW{1'b0}};
        pf_stat[`PSM_PF_SOV_BIT] = pack_overvoltage_permanent_flag_q;
        batt_stat = {DW{1'b0}};
        batt_stat[`PSM_BS_TCA_BIT] = terminate_charge_alarm;
        batt_stat[`PSM_BS_TDA_BIT] = terminate_discharge_alarm;
        batt_stat[`PSM_BS_OTA_BIT] = charge_overtemp_flag_q || discharge_overtemp_flag_q;
        op_stat = {DW{1'b0}};
        op_stat[`PSM_OS_DISCHARGE_DISABLED_FLAG_BIT] = host_inactivity_fault_q;
    end

    // register reads, data one cycle after the strobe; fault value is the one before the clear
    always @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata_q <= {DW{1'b0}};
        end else if (reg_rd) begin
            case (reg_addr)
                `PSM_ADDR_CONFIG:     reg_rdata_q <= config_q;
                `PSM_ADDR_OTC_THRESH: reg_rdata_q <= otc_thresh_q;
                `PSM_ADDR_OTC_RECOV:  reg_rdata_q <= otc_recov_q;
                `PSM_ADDR_OTD_THRESH: reg_rdata_q <= otd_thresh_q;
                `PSM_ADDR_OTD_RECOV:  reg_rdata_q <= otd_recov_q;
                `PSM_ADDR_CHG_CUR_TH: reg_rdata_q <= chg_cur_th_q;
                `PSM_ADDR_DSG_CUR_TH: reg_rdata_q <= dsg_cur_th_q;
                `PSM_ADDR_OTC_TIME:   reg_rdata_q <= otc_time_q;
                `PSM_ADDR_OTD_TIME:   reg_rdata_q <= otd_time_q;
                `PSM_ADDR_WDOG_TIME:  reg_rdata_q <= wdog_time_q;
                `PSM_ADDR_SOV_THRESH: reg_rdata_q <= sov_thresh_q;
                `PSM_ADDR_SOV_TIME:   reg_rdata_q <= sov_time_q;
                `PSM_ADDR_SAFE_ALERT: reg_rdata_q <= safe_alert;
                `PSM_ADDR_SAFE_STAT:  reg_rdata_q <= safe_stat;
                `PSM_ADDR_PERMANENT_FAIL_ALERT_WORD:   reg_rdata_q <= permanent_fail_alert_word;
                `PSM_ADDR_PF_STAT:    reg_rdata_q <= pf_stat;
                `PSM_ADDR_BATT_STAT:  reg_rdata_q <= batt_stat;
                `PSM_ADDR_OP_STAT:    reg_rdata_q <= op_stat;
                `PSM_ADDR_FUSE_FLAG:  reg_rdata_q <= fuse_flag_q;
                `PSM_ADDR_SNAP_VOLT:  reg_rdata_q <= snap_volt_q;
                `PSM_ADDR_SNAP_CUR:   reg_rdata_q <= snap_cur_q;
                `PSM_ADDR_SNAP_TEMP:  reg_rdata_q <= snap_temp_q;
                default:              reg_rdata_q <= {DW{1'b0}};
            endcase
        end else begin
            reg_rdata_q <= {DW{1'b0}};
        end
    end

    // protection outputs
    always @(posedge mclk) begin
        if (sys_rst) begin
            chg_current_req_q    <= {DW{1'b0}};
            chg_voltage_req_q    <= {DW{1'b0}};
            chg_switch_open_q    <= 1'b0;
            dsg_switch_open_q    <= 1'b0;
            prechg_switch_open_q <= 1'b0;
            fuse_blow_q          <= 1'b0;
            nv_write_block_q     <= 1'b0;
        end else begin
            // current forced to zero by every fault, voltage not by discharge overtemp
            if (charge_overtemp_flag_q || discharge_overtemp_flag_q || host_inactivity_fault_q ||
                pack_overvoltage_permanent_flag_q) begin
                chg_current_req_q <= {DW{1'b0}};
            end else begin
                chg_current_req_q <= chg_current_in;
            end
            if (charge_overtemp_flag_q || host_inactivity_fault_q ||
                pack_overvoltage_permanent_flag_q) begin
                chg_voltage_req_q <= {DW{1'b0}};
            end else begin
                chg_voltage_req_q <= chg_voltage_in;
            end
            chg_switch_open_q <= (charge_overtemp_flag_q && overtemp_switch_open_enable) ||
                                 (host_inactivity_fault_q && wdog_switch_enable) ||
                                 pack_overvoltage_permanent_flag_q;
            dsg_switch_open_q <= (discharge_overtemp_flag_q && overtemp_switch_open_enable) ||
                                 (host_inactivity_fault_q && wdog_switch_enable) ||
                                 pack_overvoltage_permanent_flag_q;
            prechg_switch_open_q <= (host_inactivity_fault_q && wdog_switch_enable) ||
                                    pack_overvoltage_permanent_flag_q;
            fuse_blow_q      <= pack_overvoltage_permanent_flag_q &&
                                (fuse_flag_q == `PSM_FUSE_MAGIC);
            nv_write_block_q <= pack_overvoltage_permanent_flag_q;
        end
    end
endmodule

// file: verification/psm_checker.sv
// port checker for the pack safety fault monitor
`timescale 1ns/1ns
module psm_checker #(
    parameter DW = 16
) (
    // clock and reset
    input wire logic          mclk,
    input wire logic          sys_rst,
    // register port
    input wire logic          reg_rd,
    input wire logic [DW-1:0] reg_rdata_q,
    // charge requests
    input wire logic [DW-1:0] chg_current_in,
    input wire logic [DW-1:0] chg_voltage_in,
    input wire logic [DW-1:0] chg_current_req_q,
    input wire logic [DW-1:0] chg_voltage_req_q,
    // protection outputs
    input wire logic          chg_switch_open_q,
    input wire logic          dsg_switch_open_q,
    input wire logic          prechg_switch_open_q,
    input wire logic          fuse_blow_q,
    input wire logic          nv_write_block_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    rdata_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata_q == '0)
        else $error("read data not zero outside read slot");
    volt_req_pass_a: assert property (chg_voltage_req_q == '0 || chg_voltage_req_q == $past(chg_voltage_in))
        else $error("voltage request neither input nor zero");
    cur_req_pass_a: assert property (chg_current_req_q == '0 || chg_current_req_q == $past(chg_current_in))
        else $error("current request neither input nor zero");
    fuse_stays_a: assert property (fuse_blow_q |=> fuse_blow_q)
        else $error("fuse output dropped");
    nv_block_stays_a: assert property (nv_write_block_q |=> nv_write_block_q)
        else $error("write block dropped");
    fuse_all_open_a: assert property (fuse_blow_q |-> nv_write_block_q && chg_switch_open_q
        && dsg_switch_open_q && prechg_switch_open_q)
        else $error("fuse fired without full shutdown");
    block_zero_req_a: assert property (nv_write_block_q |=> chg_current_req_q == '0 && chg_voltage_req_q == '0)
        else $error("requests not zero under permanent fault");
    prechg_all_open_a: assert property (prechg_switch_open_q |-> chg_switch_open_q && dsg_switch_open_q)
        else $error("precharge opened alone");
    chg_open_zero_a: assert property ($rose(chg_switch_open_q) |-> ##[0:1]
        (chg_current_req_q == '0 && chg_voltage_req_q == '0))
        else $error("charge switch opened with live requests");
    dsg_open_zero_a: assert property ($rose(dsg_switch_open_q) |-> ##[0:1] chg_current_req_q == '0)
        else $error("discharge switch opened with live current request");
    cov_fuse_c: cover property (fuse_blow_q);
    cov_chg_c: cover property ($rose(chg_switch_open_q));
    cov_dsg_c: cover property ($rose(dsg_switch_open_q));
endmodule

// file: verification/psm_host_model.sv
// management bus host model driving the register port
`timescale 1ns/1ns
module psm_host_model (
    // clock
    input  wire logic        mclk,
    // register port
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata_q
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // every call is host traffic that feeds the watchdog
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        // read data stand only in this cycle, taken once settled
        @(negedge mclk);
        d = reg_rdata_q;
    endtask
endmodule

// file: verification/psm_monitor_bench.sv
// testbench for the pack safety fault monitor
`timescale 1ns/1ns
module psm_monitor_bench;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q, cur_req, volt_req;
    logic [15:0] temp = 16'h0000, cur = 16'h0000, volt = 16'h0100;
    logic [15:0] cur_in = 16'h0100, volt_in = 16'h0200;
    logic        reg_wr, reg_rd, chg_open, dsg_open, pre_open, fuse, nvblk;
    logic        normal = 1'b1, bus_low = 1'b0;
    int          fails = 0, n_compared = 0;
    always #5 mclk = ~mclk;
    psm_monitor #(.DW(16), .TICK_CYCLES(10)) psm_monitor_inst (.mclk(mclk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .pack_temp(temp), .pack_current(cur), .pack_voltage(volt), .normal_mode(normal), .bus_low_expired(bus_low),
        .chg_current_in(cur_in), .chg_voltage_in(volt_in), .chg_current_req_q(cur_req), .chg_voltage_req_q(volt_req),
        .chg_switch_open_q(chg_open), .dsg_switch_open_q(dsg_open), .prechg_switch_open_q(pre_open),
        .fuse_blow_q(fuse), .nv_write_block_q(nvblk));
    psm_host_model psm_host_model_inst (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        psm_host_model_inst.rd(a, d);
        chk(d, exp);
    endtask
    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t_defaults;
        rdchk(8'h04, 16'h0037);
        rdchk(8'h08, 16'h0032);
        rdchk(8'h0c, 16'h003c);
        rdchk(8'h10, 16'h0037);
        rdchk(8'h7c, 16'h0000);
    endtask
    task automatic t_otc;
        psm_host_model_inst.wr(8'h00, 16'h0001);
        temp <= 16'h0037;
        cur <= 16'h0065;
        repeat (2) @(posedge mclk);
        rdchk(8'h30, 16'h0001);
        temp <= 16'h0000;
        repeat (3) @(posedge mclk);
        rdchk(8'h30, 16'h0000);
        rdchk(8'h34, 16'h0000);
        temp <= 16'h0037;
        repeat (40) @(posedge mclk);
        rdchk(8'h34, 16'h0001);
        rdchk(8'h40, 16'h0005);
        chk({15'h0, chg_open}, 16'h0001);
        chk(cur_req, 16'h0000);
        chk(volt_req, 16'h0000);
        temp <= 16'h0033;
        repeat (3) @(posedge mclk);
        rdchk(8'h34, 16'h0001);
        temp <= 16'h0032;
        repeat (3) @(posedge mclk);
        rdchk(8'h34, 16'h0000);
        chk({15'h0, chg_open}, 16'h0000);
        cur <= 16'h0000;
    endtask
    task automatic t_otd;
        psm_host_model_inst.wr(8'h00, 16'h0000);
        psm_host_model_inst.wr(8'h20, 16'h0000);
        temp <= 16'h003c;
        cur <= 16'hff9b;
        repeat (40) @(posedge mclk);
        rdchk(8'h34, 16'h0000);
        psm_host_model_inst.wr(8'h20, 16'h0002);
        repeat (40) @(posedge mclk);
        rdchk(8'h34, 16'h0002);
        rdchk(8'h40, 16'h0006);
        chk({15'h0, dsg_open}, 16'h0000);
        chk(cur_req, 16'h0000);
        chk(volt_req, volt_in);
        temp <= 16'h0037;
        repeat (3) @(posedge mclk);
        rdchk(8'h34, 16'h0000);
        cur <= 16'h0000;
    endtask
    task automatic t_wdog;
        psm_host_model_inst.wr(8'h24, 16'h0003);
        psm_host_model_inst.wr(8'h00, 16'h0004);
        repeat (50) @(posedge mclk);
        chk({15'h0, pre_open}, 16'h0001);
        chk({15'h0, dsg_open}, 16'h0001);
        chk(volt_req, 16'h0000);
        rdchk(8'h44, 16'h0001);
        rdchk(8'h34, 16'h0000);
        repeat (50) @(posedge mclk);
        rdchk(8'h34, 16'h0004);
        rdchk(8'h34, 16'h0000);
        bus_low <= 1'b1;
        repeat (50) @(posedge mclk);
        rdchk(8'h34, 16'h0000);
        bus_low <= 1'b0;
        normal <= 1'b0;
        repeat (50) @(posedge mclk);
        rdchk(8'h34, 16'h0000);
        normal <= 1'b1;
        psm_host_model_inst.wr(8'h24, 16'h0000);
    endtask
    task automatic t_sov;
        psm_host_model_inst.wr(8'h28, 16'h1000);
        volt <= 16'h1000;
        repeat (40) @(posedge mclk);
        rdchk(8'h38, 16'h0000);
        psm_host_model_inst.wr(8'h00, 16'h0002);
        psm_host_model_inst.wr(8'h2c, 16'h0001);
        repeat (40) @(posedge mclk);
        rdchk(8'h3c, 16'h0001);
        rdchk(8'h48, 16'h3672);
        chk({15'h0, fuse}, 16'h0001);
        chk({15'h0, nvblk}, 16'h0001);
        chk({15'h0, chg_open}, 16'h0001);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        t_defaults;
        t_otc;
        t_otd;
        t_wdog;
        t_sov;
        results;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        results;
    end
endmodule
bind psm_monitor psm_checker #(.DW(DW)) psm_checker_inst (.mclk(mclk), .sys_rst(sys_rst), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .chg_current_in(chg_current_in), .chg_voltage_in(chg_voltage_in),
    .chg_current_req_q(chg_current_req_q), .chg_voltage_req_q(chg_voltage_req_q),
    .chg_switch_open_q(chg_switch_open_q), .dsg_switch_open_q(dsg_switch_open_q),
    .prechg_switch_open_q(prechg_switch_open_q), .fuse_blow_q(fuse_blow_q), .nv_write_block_q(nv_write_block_q));
